// file: rtl/fsd_status.sv
// fsd_status: station state code, diagnostic fetch, change flag and diagnostic block read.
// assumes the protocol engine reports conditions as levels and fetch bytes after FETCH_REQ.
module fsd_status
  import fsd_pkg::*;
#(
  parameter bit GATEWAY = 1'b0,
  parameter int DIAG_LEN_MAX = DIAG_MAX
)
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [NUM_COND:0] COND,
  input wire logic SLAVE_SIDE,
  input wire logic [7:0] STATION_ADDR,
  input wire logic DIAG_FLAG_SEEN,
  input wire logic CYCLE_END,
  input wire logic FETCH_VALID,
  input wire logic [7:0] FETCH_DATA,
  input wire logic FETCH_LAST,
  input wire logic RX_ERR_EVT,
  input wire logic REPEAT_EVT,
  input wire logic [3:0] REPEAT_NUM,
  input wire logic HOST_RD_REQ,
  input wire logic [15:0] HOST_PORT,
  input wire logic [31:0] HOST_IGRP,
  input wire logic [OFS_W-1:0] HOST_OFFSET,
  input wire logic [OFS_W-1:0] HOST_LEN,
  output logic [7:0] STATION_STATE_CODE,
  output logic DIAG_CHANGED_FLAG,
  output logic FETCH_REQ,
  output logic HOST_RD_READY,
  output logic HOST_RD_VALID,
  output logic [7:0] HOST_RD_DATA,
  output logic HOST_RD_DONE,
  output logic HOST_RD_ERR
);

  if (DIAG_LEN_MAX < 1 || DIAG_LEN_MAX > DIAG_MAX)
  begin : g_bad_len
    $error("fsd_status: DIAG_LEN_MAX out of range");
  end

  // ****************************************
  // station state code
  // ****************************************
  logic [NUM_COND-1:0] cond_en;
  logic [7:0] code_next;
  logic err_any;

  // slave-side waits count only on a slave station, the frame counter only in gateways
  assign cond_en[COND_WC_ONE-1:0] = COND[COND_WC_ONE-1:0];
  assign cond_en[COND_WC_ONE] = COND[COND_WC_ONE] & GATEWAY;
  assign cond_en[NUM_COND-1:COND_SLAVE_LO] =
    COND[NUM_COND-1:COND_SLAVE_LO] & {(NUM_COND - COND_SLAVE_LO){SLAVE_SIDE}};
  assign err_any = |cond_en;

  always_comb
  begin
    code_next = COND[COND_EXCH] ? CODE_RUN : CODE_NOT_EXCH;
    for (int i = NUM_COND - 1; i >= 0; i--)
    begin
      if (cond_en[i])
      begin
        code_next = CODE_TAB[i];
      end
    end
  end

  // refreshed every cycle so the code never holds a stale condition
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      STATION_STATE_CODE <= CODE_TAB[COND_NOTREADY];
    end
    else
    begin
      STATION_STATE_CODE <= code_next;
    end
  end

  // ****************************************
  // statistics counters
  // ****************************************
  logic [15:0] stat_w [0:NUM_REPEAT];

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      stat_w[0] <= 16'h0000;
    end
    else if (RX_ERR_EVT)
    begin
      stat_w[0] <= stat_w[0] + 16'h0001;
    end
  end

  // counters wrap; software takes differences between reads
  for (genvar k = 0; k < NUM_REPEAT; k++)
  begin : g_rep
    always_ff @(posedge CLOCK)
    begin
      if (RST)
      begin
        stat_w[k+1] <= 16'h0000;
      end
      else if (REPEAT_EVT && REPEAT_NUM == 4'(k + 1))
      begin
        stat_w[k+1] <= stat_w[k+1] + 16'h0001;
      end
    end
  end

  // ****************************************
  // control state
  // ****************************************
  fsd_state_t state_reg, state_next;
  logic pend_reg;
  logic [7:0] fidx_reg, diag_len_reg;
  logic f_v_reg, f_keep_reg, f_last_reg, mism_reg;
  logic [7:0] f_idx_reg, f_data_reg;
  logic [OFS_W-1:0] rd_ofs_reg, rd_left_reg, iss_ofs_reg;
  logic iss_v_reg, iss_last_reg;
  logic [7:0] mem_rdata, mem_raddr;

  logic take_rd, req_ok, start_fetch, issue, fetch_end, byte_diff, change_set, rd_clear;
  logic [OFS_W:0] rd_end;
  logic [OFS_W-1:0] ofs_m, iss_m;
  logic [7:0] new_len, stat_byte, rd_byte;
  logic [15:0] stat_word;
  logic in_diag, in_stat;

  assign take_rd = HOST_RD_REQ && HOST_RD_READY;
  assign rd_end = {1'b0, HOST_OFFSET} + {1'b0, HOST_LEN};
  assign req_ok = HOST_PORT == SVC_PORT && HOST_IGRP[31:24] == IGRP_TOP
    && HOST_IGRP[23:16] == STATION_ADDR && HOST_IGRP[15:0] == IGRP_LOW
    && HOST_LEN != '0 && rd_end <= (OFS_W + 1)'(BLOCK_BYTES);
  // a host read wins the slot; the fetch then waits for the next cycle end
  assign start_fetch = state_reg == FS_IDLE && pend_reg && CYCLE_END && !take_rd;
  assign issue = state_reg == FS_READ && rd_left_reg != '0;
  assign fetch_end = f_v_reg && f_last_reg;
  assign byte_diff = f_keep_reg && (f_idx_reg >= diag_len_reg || mem_rdata != f_data_reg);
  assign new_len = f_keep_reg ? f_idx_reg + 8'h01 : 8'(DIAG_LEN_MAX);
  assign change_set = fetch_end && (mism_reg || byte_diff || new_len != diag_len_reg);
  assign rd_clear = iss_v_reg && iss_last_reg;
  assign ofs_m = rd_ofs_reg - OFS_W'(STAT_BYTES);
  assign mem_raddr = state_reg == FS_FETCH ? fidx_reg : ofs_m[7:0];

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      FS_IDLE:
      begin
        if (take_rd && req_ok)
        begin
          state_next = FS_READ;
        end
        else if (start_fetch)
        begin
          state_next = FS_FETCH;
        end
      end
      FS_FETCH:
      begin
        if (fetch_end)
        begin
          state_next = FS_IDLE;
        end
      end
      FS_READ:
      begin
        if (issue && rd_left_reg == OFS_W'(1))
        begin
          state_next = FS_IDLE;
        end
      end
      default:
      begin
        state_next = FS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      state_reg <= FS_IDLE;
      HOST_RD_READY <= 1'b0;
      FETCH_REQ <= 1'b0;
      pend_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      HOST_RD_READY <= state_next == FS_IDLE;
      FETCH_REQ <= start_fetch;
      pend_reg <= DIAG_FLAG_SEEN || (pend_reg && !start_fetch);
    end
  end

  // ****************************************
  // diagnostic fetch: compare one byte behind the store read
  // ****************************************
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      fidx_reg <= 8'h00;
      f_v_reg <= 1'b0;
      f_keep_reg <= 1'b0;
      f_last_reg <= 1'b0;
      f_idx_reg <= 8'h00;
      f_data_reg <= 8'h00;
      mism_reg <= 1'b0;
      diag_len_reg <= 8'h00;
    end
    else
    begin
      f_v_reg <= state_reg == FS_FETCH && FETCH_VALID && !fetch_end;
      f_keep_reg <= fidx_reg < 8'(DIAG_LEN_MAX);
      f_last_reg <= FETCH_LAST;
      f_idx_reg <= fidx_reg;
      f_data_reg <= FETCH_DATA;
      if (start_fetch)
      begin
        fidx_reg <= 8'h00;
        mism_reg <= 1'b0;
      end
      else if (state_reg == FS_FETCH && FETCH_VALID && fidx_reg != 8'hFF)
      begin
        fidx_reg <= fidx_reg + 8'h01;
      end
      if (f_v_reg && byte_diff)
      begin
        mism_reg <= 1'b1;
      end
      if (fetch_end)
      begin
        diag_len_reg <= new_len;
      end
    end
  end

  // a fresh change in the clearing cycle wins over the host's clear
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      DIAG_CHANGED_FLAG <= 1'b0;
    end
    else if (change_set)
    begin
      DIAG_CHANGED_FLAG <= 1'b1;
    end
    else if (rd_clear)
    begin
      DIAG_CHANGED_FLAG <= 1'b0;
    end
  end

  fsd_diag_mem #(
    .DEPTH(256),
    .AW(8)
  ) u_mem (
    .clk(CLOCK),
    .rst(RST),
    .we(f_v_reg && f_keep_reg),
    .waddr(f_idx_reg),
    .wdata(f_data_reg),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ****************************************
  // host block read
  // ****************************************
  assign iss_m = iss_ofs_reg - OFS_W'(STAT_BYTES);
  assign in_stat = iss_ofs_reg < OFS_W'(STAT_USED_BYTES);
  assign in_diag = iss_ofs_reg >= OFS_W'(STAT_BYTES) && iss_m[7:0] < diag_len_reg;
  assign stat_word = stat_w[iss_ofs_reg[4:1]];
  assign stat_byte = iss_ofs_reg[0] ? stat_word[15:8] : stat_word[7:0];
  // unused statistic bytes and bytes past the stored length read as zero
  assign rd_byte = in_stat ? stat_byte : (in_diag ? mem_rdata : 8'h00);

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      rd_ofs_reg <= '0;
      rd_left_reg <= '0;
      iss_v_reg <= 1'b0;
      iss_last_reg <= 1'b0;
      iss_ofs_reg <= '0;
      HOST_RD_VALID <= 1'b0;
      HOST_RD_DATA <= 8'h00;
      HOST_RD_DONE <= 1'b0;
      HOST_RD_ERR <= 1'b0;
    end
    else
    begin
      HOST_RD_ERR <= take_rd && !req_ok;
      if (take_rd && req_ok)
      begin
        rd_ofs_reg <= HOST_OFFSET;
        rd_left_reg <= HOST_LEN;
      end
      else if (issue)
      begin
        rd_ofs_reg <= rd_ofs_reg + OFS_W'(1);
        rd_left_reg <= rd_left_reg - OFS_W'(1);
      end
      iss_v_reg <= issue;
      iss_last_reg <= rd_left_reg == OFS_W'(1);
      iss_ofs_reg <= rd_ofs_reg;
      HOST_RD_VALID <= iss_v_reg;
      HOST_RD_DATA <= iss_v_reg ? rd_byte : 8'h00;
      HOST_RD_DONE <= rd_clear;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  a_code_run: assert property (
    STATION_STATE_CODE == CODE_RUN |-> $past(COND[COND_EXCH]) && !$past(err_any))
    else $error("code 0 without clean data exchange");
  a_code_deact: assert property (
    COND[2] && !COND[1] && !COND[0] |=> STATION_STATE_CODE == 8'h01)
    else $error("deactivated station not reported as 1");
  a_code_task: assert property (
    COND[COND_TASKWAIT] |=> STATION_STATE_CODE == 8'h12)
    else $error("task wait not reported as 18");
  a_code_slave: assert property (
    !SLAVE_SIDE && $past(!SLAVE_SIDE) |-> STATION_STATE_CODE < 8'h80)
    else $error("slave code on a master station");
  a_code_follow: assert property (
    !$past(RST) && $stable(COND) && $stable(SLAVE_SIDE) |=> $stable(STATION_STATE_CODE))
    else $error("state code moved with steady conditions");
  a_fetch_gap: assert property (
    FETCH_REQ |-> $past(CYCLE_END) && $past(pend_reg))
    else $error("fetch outside the cycle gap");
  a_fetch_auto: assert property (
    DIAG_FLAG_SEEN && HOST_RD_READY && !HOST_RD_REQ && !CYCLE_END
      ##1 CYCLE_END && !HOST_RD_REQ |=> FETCH_REQ)
    else $error("flagged diagnosis not fetched");
  a_flag_same: assert property (
    $rose(DIAG_CHANGED_FLAG) |-> $past(fetch_end))
    else $error("change flag raised without a fetch");
  a_flag_clear: assert property (
    HOST_RD_DONE && !$past(change_set) |-> !DIAG_CHANGED_FLAG)
    else $error("host read did not clear the flag");
  a_rd_reject: assert property (
    take_rd && HOST_PORT != SVC_PORT |=> HOST_RD_ERR ##1 !HOST_RD_VALID[*2])
    else $error("wrong service port accepted");
  a_rd_count: assert property (
    RX_ERR_EVT |=> stat_w[0] == $past(stat_w[0]) + 16'h0001)
    else $error("faulty telegram not counted");

  c_fetch: cover property (FETCH_REQ ##[1:40] $rose(DIAG_CHANGED_FLAG));
  c_read: cover property (take_rd && req_ok ##[3:300] HOST_RD_DONE);
  c_clash: cover property (change_set && rd_clear);
  c_slave: cover property (STATION_STATE_CODE == 8'h80);

endmodule : fsd_status

// file: rtl/fsd_pkg.sv
// fsd_pkg: constants shared by the station diagnostic status block and its memory.
// assumes one 125 MHz clock and a synchronous active-high reset everywhere.
package fsd_pkg;

  // ****************************************
  // diagnostic block layout
  // ****************************************
  localparam int STAT_BYTES = 32;
  localparam int DIAG_MAX = 244;
  localparam int BLOCK_BYTES = 276;
  localparam int OFS_W = 9;
  localparam int NUM_REPEAT = 8;
  localparam int STAT_RXERR_OFS = 0;
  localparam int STAT_REPEAT_OFS = 2;
  localparam int STAT_USED_BYTES = 18;

  // ****************************************
  // host service addressing
  // ****************************************
  localparam logic [15:0] SVC_PORT = 16'h00C8;
  localparam logic [15:0] IGRP_LOW = 16'hF181;
  localparam logic [7:0] IGRP_TOP = 8'h00;

  // ****************************************
  // condition inputs, index 0 has the highest priority
  // ****************************************
  localparam int NUM_COND = 24;
  localparam int COND_TASKWAIT = 0;
  localparam int COND_NOTREADY = 1;
  localparam int COND_WC_ONE = 18;
  localparam int COND_SLAVE_LO = 19;
  localparam int COND_EXCH = 24;
  localparam logic [7:0] CODE_RUN = 8'h00;
  localparam logic [7:0] CODE_NOT_EXCH = 8'h0C;
  // code per condition bit, bit 23 leftmost
  localparam logic [NUM_COND-1:0][7:0] CODE_TAB = '{
    8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h1F,
    8'h11, 8'h10, 8'h0F, 8'h0E, 8'h0D, 8'h0C, 8'h0B, 8'h0A, 8'h09,
    8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h08, 8'h12};

  typedef enum logic [2:0] {
    FS_IDLE = 3'b001,
    FS_FETCH = 3'b010,
    FS_READ = 3'b100
  } fsd_state_t;

endpackage : fsd_pkg

// file: rtl/fsd_diag_mem.sv
// fsd_diag_mem: byte store for the slave's reported diagnostic bytes.
// assumes one write port and one read port on the same clock; read data is registered.
module fsd_diag_mem
  import fsd_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:DEPTH-1];

  if (DEPTH > (1 << AW))
  begin : g_bad_depth
    $error("fsd_diag_mem: DEPTH does not fit AW");
  end

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // contents are not reset; the stored length decides what is valid
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end

endmodule : fsd_diag_mem

// file: sim/fsd_engine_model.sv
// fsd_engine_model: protocol engine side that answers a diagnostic fetch.
// assumes the bench sets length, first byte and pacing before the fetch starts.
module fsd_engine_model
(
  input wire logic clk,
  input wire logic fetch_req,
  input wire logic [8:0] len,
  input wire logic [7:0] base,
  input wire logic slow,
  output logic fetch_valid,
  output logic [7:0] fetch_data,
  output logic fetch_last
);
  timeunit 1ns;
  timeprecision 1ps;
  int i;
  // ****
  // byte stream
  // ****
  initial
  begin
    fetch_valid = 1'b0;
    fetch_data = 8'h5A;
    fetch_last = 1'b0;
    forever
    begin
      @(posedge clk);
      if (fetch_req === 1'b1)
      begin
        for (i = 0; i < len; i++)
        begin
          fetch_valid <= 1'b1;
          fetch_data <= base + 8'(i);
          fetch_last <= (i == len - 1);
          @(posedge clk);
          if (slow)
          begin
            // idle data is inverted so a late sample cannot match by luck
            fetch_valid <= 1'b0;
            fetch_data <= ~fetch_data;
            fetch_last <= 1'b0;
            @(posedge clk);
          end
        end
        fetch_valid <= 1'b0;
        fetch_data <= ~fetch_data;
        fetch_last <= 1'b0;
      end
    end
  end
endmodule : fsd_engine_model

// file: sim/fsd_status_test.sv
// fsd_status_test: self-checking bench for the station diagnostic status block.
// assumes the engine model answers fetches; conditions and host reads come from here.
module fsd_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst = 1'b1, slave_side = 1'b1;
  logic [24:0] cond = '0;
  logic [7:0] addr = 8'h23;
  logic flag_seen = 1'b0, cycle_end = 1'b0, rx_err = 1'b0, rep_evt = 1'b0, rd_req = 1'b0;
  logic [3:0] rep_num = 4'h1;
  logic [15:0] h_port = '0;
  logic [31:0] h_igrp = '0;
  logic [8:0] h_ofs = '0, h_len = '0, m_len = '0;
  logic [7:0] m_base = '0, f_data, code, rdata;
  logic m_slow = 1'b0;
  logic f_valid, f_last, flag, f_req, rdy, rvalid, rdone, rerr;
  logic [7:0] rbuf [0:299];
  int n_errors = 0, checks = 0, cycles = 0;

  fsd_status #(.GATEWAY(1'b1), .DIAG_LEN_MAX(244)) fsd_status_i (
    .CLOCK(clock), .RST(rst), .COND(cond), .SLAVE_SIDE(slave_side), .STATION_ADDR(addr),
    .DIAG_FLAG_SEEN(flag_seen), .CYCLE_END(cycle_end), .FETCH_VALID(f_valid),
    .FETCH_DATA(f_data), .FETCH_LAST(f_last), .RX_ERR_EVT(rx_err), .REPEAT_EVT(rep_evt),
    .REPEAT_NUM(rep_num), .HOST_RD_REQ(rd_req), .HOST_PORT(h_port), .HOST_IGRP(h_igrp),
    .HOST_OFFSET(h_ofs), .HOST_LEN(h_len), .STATION_STATE_CODE(code),
    .DIAG_CHANGED_FLAG(flag), .FETCH_REQ(f_req), .HOST_RD_READY(rdy),
    .HOST_RD_VALID(rvalid), .HOST_RD_DATA(rdata), .HOST_RD_DONE(rdone), .HOST_RD_ERR(rerr));

  fsd_engine_model fsd_engine_model_i (.clk(clock), .fetch_req(f_req), .len(m_len),
    .base(m_base), .slow(m_slow), .fetch_valid(f_valid), .fetch_data(f_data),
    .fetch_last(f_last));

  always #4 clock = ~clock;

  // ****
  // common tasks
  // ****
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // a hung handshake ends the run as a failure
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic set_cond(input logic [24:0] v);
    cond <= v;
    repeat (2) @(posedge clock);
  endtask : set_cond

  task automatic host_read(input logic [15:0] port, input logic [31:0] grp, input int ofs,
      input int len, output int nb, output logic er);
    int k;
    nb = 0;
    er = 1'b0;
    k = 0;
    while (rdy !== 1'b1 && k < 300)
    begin
      @(posedge clock);
      k++;
    end
    rd_req <= 1'b1;
    h_port <= port;
    h_igrp <= grp;
    h_ofs <= 9'(ofs);
    h_len <= 9'(len);
    @(posedge clock);
    rd_req <= 1'b0;
    for (k = 0; k < 300; k++)
    begin
      @(posedge clock);
      if (rvalid === 1'b1)
      begin
        rbuf[nb] = rdata;
        nb++;
      end
      if (rerr === 1'b1)
        er = 1'b1;
      if (rdone === 1'b1 || rerr === 1'b1)
        break;
    end
  endtask : host_read

  // ****
  // scenarios
  // ****
  task automatic test_codes();
    logic [7:0] tab [24] = '{8'h12, 8'h08, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h1F, 8'h84, 8'h83,
      8'h82, 8'h81, 8'h80};
    for (int i = 0; i < 24; i++)
    begin
      set_cond((25'd1 << i) | (25'd1 << (i + 1)));
      check(code, tab[i], "state code");
    end
    set_cond(25'h1000000);
    check(code, 8'h00, "exchange without fault");
    set_cond(25'h1000020);
    check(code, 8'h04, "exchange with fault");
    slave_side <= 1'b0;
    set_cond(25'h0080000);
    check(code, 8'h0C, "slave code on master");
    slave_side <= 1'b1;
    set_cond(25'h0);
    check(code, 8'h0C, "code follows drop");
  endtask : test_codes

  task automatic test_stats();
    int nb;
    logic er;
    for (int i = 0; i < 3; i++)
    begin
      rx_err <= 1'b1;
      rep_evt <= (i != 1);
      rep_num <= (i == 0) ? 4'h1 : 4'h8;
      @(posedge clock);
      rx_err <= 1'b0;
      rep_evt <= 1'b0;
      @(posedge clock);
    end
    host_read(16'h00C8, {8'h00, addr, 16'hF181}, 0, 18, nb, er);
    check({rbuf[1], rbuf[0]}, 16'h0003, "faulty count");
    check({rbuf[3], rbuf[2]}, 16'h0001, "single repeat count");
    check({rbuf[5], rbuf[4]}, 16'h0000, "double repeat count");
    check({rbuf[17], rbuf[16]}, 16'h0001, "eight repeat count");
  endtask : test_stats

  task automatic expect_err(input logic [15:0] port, input logic [31:0] grp, input int ofs,
      input int len);
    int nb;
    logic er;
    host_read(port, grp, ofs, len, nb, er);
    check({15'(nb), er}, 16'h0001, "refused read");
  endtask : expect_err

  task automatic test_refused();
    int nb;
    logic er;
    expect_err(16'h00C9, 32'h0023F181, 0, 4);
    expect_err(16'h00C8, 32'h0123F181, 0, 4);
    expect_err(16'h00C8, 32'h0024F181, 0, 4);
    expect_err(16'h00C8, 32'h0023F182, 0, 4);
    expect_err(16'h00C8, 32'h0023F181, 0, 0);
    expect_err(16'h00C8, 32'h0023F181, 273, 4);
    host_read(16'h00C8, 32'h0023F181, 272, 4, nb, er);
    check({15'(nb), er}, 16'h0008, "read to block end");
  endtask : test_refused

  task automatic do_fetch(input logic [7:0] base, input int len, input logic slow,
      input logic exp_flag);
    int k;
    m_base <= base;
    m_len <= 9'(len);
    m_slow <= slow;
    flag_seen <= 1'b1;
    @(posedge clock);
    flag_seen <= 1'b0;
    // the slow run puts the cycle end right behind the flag
    if (!slow)
    begin
      for (k = 0; k < 3; k++)
      begin
        @(posedge clock);
        check(f_req, 1'b0, "fetch before cycle end");
      end
    end
    cycle_end <= 1'b1;
    @(posedge clock);
    cycle_end <= 1'b0;
    @(posedge clock);
    check(f_req, 1'b1, "automatic fetch");
    k = 0;
    while (rdy !== 1'b1 && k < 1000)
    begin
      @(posedge clock);
      k++;
    end
    check(flag, exp_flag, "change flag after fetch");
  endtask : do_fetch

  task automatic read_diag(input logic [7:0] base, input int len);
    int nb;
    logic er;
    host_read(16'h00C8, {8'h00, addr, 16'hF181}, 32, len + 2, nb, er);
    check(16'(nb), 16'(len + 2), "diag byte count");
    for (int i = 0; i < len + 2; i++)
      check(rbuf[i], (i < len) ? base + 8'(i) : 8'h00, "diag byte");
    @(posedge clock);
    check(flag, 1'b0, "flag after host read");
  endtask : read_diag

  initial
  begin
    repeat (4) @(posedge clock);
    check(code, 8'h08, "code after reset");
    check(flag, 1'b0, "flag after reset");
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    check(code, 8'h0C, "code after release");
    test_codes();
    test_stats();
    test_refused();
    do_fetch(8'h40, 4, 1'b0, 1'b1);
    read_diag(8'h40, 4);
    do_fetch(8'h40, 4, 1'b0, 1'b0);
    do_fetch(8'h70, 5, 1'b1, 1'b1);
    read_diag(8'h70, 5);
    report_and_stop();
  end
endmodule : fsd_status_test
